// ---- smbus_ctl_pkg.sv ----
// Shared constants, register map and types of the two-wire bus control logic.
package smbus_ctl_pkg;

   // Register map: byte addresses on the plain register port.
   localparam logic [7:0] CTL_ADDR = 8'hc0;
   localparam logic [7:0] CFG_ADDR = 8'hc1;
   localparam logic [7:0] DAT_ADDR = 8'hc2;
   // Single-bit write window: address BITW_BASE + n writes wdata[0] to control bit n when bit n is writable.
   localparam logic [7:0] BITW_BASE = 8'h80;
   localparam logic [7:0] BITW_SPAN_MASK = 8'hf8;

   // Control register bit positions; the last one is the auto-response bit 0 of the CFG register.
   localparam int MASTER_BIT = 7;
   localparam int TXDIR_BIT = 6;
   localparam int START_BIT = 5;
   localparam int STOP_BIT = 4;
   localparam int RREQ_BIT = 3;
   localparam int ARB_BIT = 2;
   localparam int ACK_BIT = 1;
   localparam int SI_BIT = 0;
   localparam int AUTO_BIT = 0;

   // Values after reset and the set of software-writable control bits.
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] CTL_WR_MASK = 8'h33;
   localparam logic [7:0] DAT_RESET = 8'h00;
   localparam logic AUTO_RESET = 1'b0;

   // Bit counter milestones within one byte frame.
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] ACK_DONE = 4'h9;

   // Bus timing: half a bit period, a longest time, rounded down.
   localparam int unsigned REF_CLK_HZ = 25000000;
   localparam int unsigned BUS_RATE_HZ = 100000;
   localparam int unsigned HALF_BIT_CYCLES = REF_CLK_HZ / (2 * BUS_RATE_HZ);

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_START = 4'h1,
      ST_LOW = 4'h3,
      ST_HIGH = 4'h2,
      ST_STALL = 4'h6,
      ST_STOP_A = 4'h7,
      ST_STOP_B = 4'h5,
      ST_STOP_C = 4'h4,
      ST_RS_A = 4'hc,
      ST_RS_B = 4'hd,
      ST_SLAVE = 4'hf
   } state_t;

   // Field order matches the control register bit order, bit 7 first.
   typedef struct packed {
      logic master_role;
      logic transmit_direction_flag;
      logic start_flag;
      logic stop_flag;
      logic response_request_flag;
      logic arbitration_loss_flag;
      logic ack_bit;
      logic event_flag;
   } ctl_t;

endpackage

// ---- pin_sync.sv ----
// Two-flop synchroniser for bus pins sampled by the reference clock.
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 2,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t q;
   sync_t d;

   always_comb begin
      d.s1 = async_in;
      d.s2 = q.s1;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         q <= {RST_VAL, RST_VAL};
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.s2;
endmodule // pin_sync

// ---- tick_divider.sv ----
// Divider that turns the reference clock into a half-bit enable pulse.
`timescale 1ns/1ps
module tick_divider #(
   parameter int unsigned DIV = 125
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   output logic tick
);
   localparam int CW = $clog2(DIV);

   if (DIV < 2) begin : g_div_check
      $error("tick_divider: DIV must be at least 2");
   end

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } div_t;

   div_t q;
   div_t d;

   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (q.cnt == CW'(DIV - 1)) begin
         d.cnt = '0;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;
endmodule // tick_divider

// ---- smbus_control_status_logic.sv ----
// Control and status logic of a two-wire serial bus interface, controller and target roles.
// Operation
// [RULE_01] Controller role set on START, cleared on STOP/loss.
// [RULE_02] Direction set on START or prior data write.
// [RULE_03] Start flag set on START plus address.
// [RULE_04] Writing start flag 1 begins (repeated) START.
// [RULE_05] Stop flag sends STOP after acknowledge, then clears.
// [RULE_06] Stop flag set on STOP while addressed.
// [RULE_07] Stop flag set when STOP causes arbitration loss.
// [RULE_08] Response request set per received byte, software mode.
// [RULE_09] Arbitration lost on unwanted repeated START.
// [RULE_10] Arbitration lost if SCL low at STOP/restart.
// [RULE_11] Arbitration lost if SDA low sending one.
// [RULE_12] Acknowledge bit follows each received acknowledge slot.
// [RULE_13] Interrupt flag set on every listed bus event.
// [RULE_14] Interrupt flag set holds SCL low, stalling bus.
// [RULE_15] Writing 0 clears flag, 1 forces interrupt.
// [RULE_16] Receiver answers with last written acknowledge bit.
// [RULE_17] Unwritten acknowledge bit yields a not-acknowledge.
// [RULE_18] Both flags set: STOP then START.
// [RULE_19] Control register resets to zero, bit writes.
// [RULE_20] Writes to read-only control bits ignored.
`timescale 1ns/1ps
module smbus_control_status_logic
   import smbus_ctl_pkg::*;
#(
   parameter int unsigned HALF_BIT = smbus_ctl_pkg::HALF_BIT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);
   import smbus_ctl_pkg::*;

   if (HALF_BIT < 4) begin : g_half_bit_check
      $error("smbus_control_status_logic: HALF_BIT too small for pin sampling");
   end

   typedef struct packed {
      state_t st;
      ctl_t ctl;
      logic auto_response_enable;
      logic [7:0] shift_data_byte;
      logic [3:0] bitcnt;
      logic busy;
      logic addr_phase;
      logic addressed;
      logic dat_written;
      logic ack_written;
      logic sent_ack;
      logic scl_p;
      logic sda_p;
      logic scl_low;
      logic scl_oe;
      logic sda_oe;
      logic scl_out;
      logic sda_out;
      logic [7:0] rdata;
   } core_t;

   core_t q;
   core_t d;
   logic [1:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic tick;

   pin_sync #(
      .W(2),
      .RST_VAL(2'h3)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .async_in({scl_in, sda_in}),
      .sync_out(pins_s)
   );

   tick_divider #(
      .DIV(HALF_BIT)
   ) u_div (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .tick(tick)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // Which control bits a write touches; read-only bits never appear in the mask.
   function automatic logic [7:0] wr_mask(input logic [7:0] addr, input logic wr);
      logic [7:0] m;
      m = 8'h00;
      if (wr && addr == CTL_ADDR) begin
         m = CTL_WR_MASK; // RULE_20
      end else if (wr && (addr & BITW_SPAN_MASK) == BITW_BASE) begin
         m = CTL_WR_MASK & (8'h01 << addr[2:0]); // RULE_19
      end
      return m;
   endfunction

   // Losing arbitration drops the controller role and releases the data line; the interrupt flag it sets keeps the clock held low.
   function automatic core_t lose(input core_t s);
      core_t r;
      r = s;
      r.ctl.master_role = 1'b0;
      r.ctl.transmit_direction_flag = 1'b0;
      r.ctl.arbitration_loss_flag = 1'b1;
      r.ctl.event_flag = 1'b1;
      r.st = ST_IDLE;
      r.sda_oe = 1'b0;
      r.scl_low = 1'b0;
      r.bitcnt = 4'h0;
      return r;
   endfunction

   logic [7:0] mask;
   logic [7:0] wbyte;
   logic si_clr;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   state_t next_frame_st;

   always_comb begin
      d = q;
      d.scl_p = scl_s;
      d.sda_p = sda_s;
      scl_rise = scl_s && !q.scl_p;
      scl_fall = !scl_s && q.scl_p;
      start_det = scl_s && q.scl_p && q.sda_p && !sda_s;
      stop_det = scl_s && q.scl_p && !q.sda_p && sda_s;
      // After a frame step a pending STOP wins; a START behind it follows from idle.
      next_frame_st = q.ctl.stop_flag ? ST_STOP_A : (q.ctl.start_flag ? ST_RS_A : ST_LOW);

      d.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            CTL_ADDR: d.rdata = q.ctl;
            CFG_ADDR: d.rdata = {7'h00, q.auto_response_enable};
            DAT_ADDR: d.rdata = q.shift_data_byte;
            default: d.rdata = 8'h00;
         endcase
      end

      mask = wr_mask(reg_addr, reg_wr);
      wbyte = (reg_addr == CTL_ADDR) ? reg_wdata : {8{reg_wdata[0]}};
      d.ctl = (q.ctl & ~mask) | (wbyte & mask); // RULE_04 RULE_15
      if (mask[ACK_BIT]) begin
         d.ack_written = 1'b1;
      end
      si_clr = q.ctl.event_flag && mask[SI_BIT] && !wbyte[SI_BIT];
      if (si_clr) begin
         d.ctl.arbitration_loss_flag = 1'b0; // RULE_11
         if (q.ctl.response_request_flag && !d.ack_written) begin
            d.ctl.ack_bit = 1'b0; // RULE_17
         end
         d.ack_written = 1'b0;
      end
      if (reg_wr && reg_addr == CFG_ADDR) begin
         d.auto_response_enable = reg_wdata[AUTO_BIT];
      end
      if (reg_wr && reg_addr == DAT_ADDR) begin
         d.shift_data_byte = reg_wdata;
         if (!q.busy) begin
            d.dat_written = 1'b1;
         end
      end

      unique case (q.st)
         ST_IDLE: begin
            d.scl_low = 1'b0;
            if (start_det) begin
               d.busy = 1'b1;
               d.ctl.transmit_direction_flag = 1'b0; // RULE_02
               d.bitcnt = 4'h0;
               d.addr_phase = 1'b1;
               d.addressed = 1'b0;
               d.st = ST_SLAVE;
            end else if (stop_det) begin
               d.busy = 1'b0;
            end else if (q.ctl.start_flag && !q.ctl.event_flag && !q.busy && tick) begin
               d.sda_oe = 1'b1; // RULE_04
               d.ctl.master_role = 1'b1; // RULE_01
               d.ctl.transmit_direction_flag = 1'b1; // RULE_02
               d.busy = 1'b1;
               d.st = ST_START;
            end
         end
         ST_START: begin
            if (tick) begin
               d.scl_low = 1'b1;
               d.ctl.event_flag = 1'b1; // RULE_13
               d.ctl.transmit_direction_flag = 1'b1;
               d.bitcnt = 4'h0;
               d.addr_phase = 1'b1;
               d.st = ST_STALL;
            end
         end
         ST_STALL: begin
            if (q.ctl.master_role && start_det && !q.ctl.start_flag) begin
               d = lose(d); // RULE_09
            end else if (q.ctl.master_role && stop_det) begin
               d = lose(d);
               d.ctl.stop_flag = 1'b1; // RULE_07
               d.busy = 1'b0;
            end else if (!q.ctl.event_flag) begin
               if (q.ctl.master_role) begin
                  d.st = (q.bitcnt == BYTE_BITS) ? ST_LOW : next_frame_st; // RULE_05 RULE_15
               end else begin
                  d.st = ST_SLAVE;
                  if (q.bitcnt == BYTE_BITS) begin
                     d.sda_oe = q.ctl.ack_bit; // RULE_16
                     d.sent_ack = q.ctl.ack_bit;
                  end else if (q.ctl.transmit_direction_flag && q.ctl.ack_bit) begin
                     d.sda_oe = !q.shift_data_byte[7];
                  end
               end
            end
         end
         ST_LOW: begin
            d.scl_low = 1'b1;
            if (tick) begin
               if (q.bitcnt < BYTE_BITS) begin
                  d.sda_oe = q.ctl.transmit_direction_flag && !q.shift_data_byte[7];
               end else begin
                  d.sda_oe = !q.ctl.transmit_direction_flag && q.ctl.ack_bit; // RULE_16
               end
               d.st = ST_HIGH;
            end
         end
         ST_HIGH: begin
            d.scl_low = 1'b0;
            if (start_det && !q.ctl.start_flag) begin
               d = lose(d); // RULE_09
            end else if (stop_det) begin
               d = lose(d);
               d.ctl.stop_flag = 1'b1; // RULE_07
               d.busy = 1'b0;
            end else if (tick && scl_s) begin
               d.scl_low = 1'b1;
               if (q.bitcnt < BYTE_BITS) begin
                  d.shift_data_byte = {q.shift_data_byte[6:0], sda_s};
                  d.bitcnt = q.bitcnt + 4'h1;
                  d.st = ST_LOW;
                  if (!q.ctl.transmit_direction_flag && q.bitcnt == BYTE_BITS - 4'h1 &&
                      !q.auto_response_enable) begin
                     d.ctl.event_flag = 1'b1; // RULE_13
                     d.ctl.response_request_flag = 1'b1; // RULE_08
                     d.st = ST_STALL;
                  end
                  if (q.ctl.transmit_direction_flag && !q.sda_oe && !sda_s) begin
                     d = lose(d); // RULE_11
                  end
               end else begin
                  if (q.ctl.transmit_direction_flag) begin
                     d.ctl.ack_bit = !sda_s; // RULE_12
                  end
                  d.ctl.response_request_flag = 1'b0; // RULE_08
                  d.sda_oe = 1'b0;
                  d.bitcnt = 4'h0;
                  if (q.addr_phase) begin
                     d.addr_phase = 1'b0;
                     d.ctl.transmit_direction_flag = !q.shift_data_byte[0];
                  end
                  if (q.ctl.transmit_direction_flag || q.auto_response_enable) begin
                     d.ctl.event_flag = 1'b1; // RULE_13
                     d.st = ST_STALL;
                  end else begin
                     d.st = next_frame_st; // RULE_05
                  end
               end
            end
         end
         ST_STOP_A: begin
            d.scl_low = 1'b1;
            d.sda_oe = 1'b1;
            if (tick) begin
               d.scl_low = 1'b0;
               d.st = ST_STOP_B;
            end
         end
         ST_STOP_B: begin
            if (tick) begin
               if (!scl_s) begin
                  d = lose(d); // RULE_10
               end else begin
                  d.sda_oe = 1'b0;
                  d.st = ST_STOP_C;
               end
            end
         end
         ST_STOP_C: begin
            if (tick) begin
               d.ctl.stop_flag = 1'b0; // RULE_05
               d.ctl.master_role = 1'b0; // RULE_01
               d.ctl.transmit_direction_flag = 1'b0;
               d.busy = 1'b0;
               d.dat_written = 1'b0;
               // A start flag still set relaunches a START from idle.
               d.st = ST_IDLE; // RULE_18
            end
         end
         ST_RS_A: begin
            d.scl_low = 1'b1;
            d.sda_oe = 1'b0;
            if (tick) begin
               d.scl_low = 1'b0;
               d.st = ST_RS_B;
            end
         end
         ST_RS_B: begin
            if (tick) begin
               if (!scl_s) begin
                  d = lose(d); // RULE_10
               end else begin
                  d.sda_oe = 1'b1; // RULE_04
                  d.st = ST_START;
               end
            end
         end
         ST_SLAVE: begin
            if (start_det) begin
               d.ctl.transmit_direction_flag = 1'b0; // RULE_02
               d.bitcnt = 4'h0;
               d.addr_phase = 1'b1;
               d.addressed = 1'b0;
               d.sda_oe = 1'b0;
            end else if (stop_det) begin
               if (q.addressed) begin
                  d.ctl.stop_flag = 1'b1; // RULE_06
                  d.ctl.event_flag = 1'b1; // RULE_13
               end
               d.busy = 1'b0;
               d.addressed = 1'b0;
               d.dat_written = 1'b0;
               d.sda_oe = 1'b0;
               d.st = ST_IDLE;
            end else if (scl_rise) begin
               d.bitcnt = q.bitcnt + 4'h1;
               if (q.bitcnt < BYTE_BITS) begin
                  d.shift_data_byte = {q.shift_data_byte[6:0], sda_s};
                  if (q.ctl.transmit_direction_flag && !q.addr_phase && !q.sda_oe && !sda_s) begin
                     d = lose(d); // RULE_11
                  end
               end else if (q.ctl.transmit_direction_flag) begin
                  d.ctl.ack_bit = !sda_s; // RULE_12
               end
            end else if (scl_fall) begin
               if (q.bitcnt == BYTE_BITS) begin
                  if (q.ctl.transmit_direction_flag && !q.addr_phase) begin
                     d.sda_oe = 1'b0;
                  end else if (q.auto_response_enable) begin
                     d.sda_oe = q.ctl.ack_bit; // RULE_16
                     d.sent_ack = q.ctl.ack_bit;
                  end else begin
                     d.ctl.event_flag = 1'b1; // RULE_13
                     d.ctl.response_request_flag = 1'b1; // RULE_08
                     d.ctl.start_flag = q.ctl.start_flag | q.addr_phase; // RULE_03
                     d.st = ST_STALL;
                  end
               end else if (q.bitcnt == ACK_DONE) begin
                  d.ctl.response_request_flag = 1'b0; // RULE_08
                  d.sda_oe = 1'b0;
                  d.bitcnt = 4'h0;
                  if (q.addr_phase) begin
                     d.addr_phase = 1'b0;
                     if (q.sent_ack) begin
                        d.addressed = 1'b1;
                        d.ctl.transmit_direction_flag =
                           q.shift_data_byte[0] && q.dat_written; // RULE_02
                        if (q.auto_response_enable) begin
                           d.ctl.event_flag = 1'b1; // RULE_13
                           d.ctl.start_flag = 1'b1; // RULE_03
                           d.st = ST_STALL;
                        end
                     end else begin
                        // Slave events are ignored until the next START.
                        d.st = ST_IDLE;
                     end
                  end else if (q.ctl.transmit_direction_flag || q.auto_response_enable) begin
                     d.ctl.event_flag = 1'b1; // RULE_13
                     d.st = ST_STALL;
                  end
               end else if (q.ctl.transmit_direction_flag && !q.addr_phase) begin
                  d.sda_oe = !q.shift_data_byte[7];
               end
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase

      // Open-drain pins: only ever pulled low, never driven high.
      d.scl_out = 1'b0;
      d.sda_out = 1'b0;
      d.scl_oe = d.ctl.event_flag || d.scl_low; // RULE_14
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.ctl <= CTL_RESET; // RULE_19
         q.auto_response_enable <= AUTO_RESET;
         q.shift_data_byte <= DAT_RESET;
         q.scl_p <= 1'b1;
         q.sda_p <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign scl_out = q.scl_out;
   assign scl_oe = q.scl_oe;
   assign sda_out = q.sda_out;
   assign sda_oe = q.sda_oe;
endmodule // smbus_control_status_logic

// ---- smbus_control_status_logic_sva.sv ----
// Port checker of the two-wire bus control logic.
`timescale 1ns/1ps
module smbus_control_status_logic_sva
   import smbus_ctl_pkg::*;
#(
   parameter int unsigned HALF_BIT = smbus_ctl_pkg::HALF_BIT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe
);
   localparam int START_MAX = 4 * HALF_BIT + 8;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside its slot");
   reset_out_a: assert property ($rose(rst_b) |-> !scl_oe && !sda_oe && reg_rdata == 8'h00)
      else $error("outputs not idle after reset");
   unmapped_read_a: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   out_zero_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("open drain output value not zero");
   force_si_a: assert property (reg_wr && reg_addr == BITW_BASE && reg_wdata[0]
      |-> ##[1:3] scl_oe)
      else $error("forced interrupt did not hold the clock");
   start_gen_a: assert property (reg_wr && reg_addr == BITW_BASE + 8'h05 && reg_wdata[0]
      && !scl_oe |-> ##[1:START_MAX] (sda_oe && !scl_oe))
      else $error("start request made no start condition");
   start_hold_a: assert property ($rose(sda_oe) && scl_in && !scl_oe
      |-> ##[1:START_MAX] scl_oe)
      else $error("clock not pulled low after start");
   stop_idle_a: assert property ($fell(sda_oe) && scl_in && !scl_oe |=> !scl_oe [*8])
      else $error("clock pulled after stop condition");
   low_hold_a: assert property ($rose(scl_oe) |-> scl_oe [*2])
      else $error("clock low phase too short");
   start_c: cover property (sda_oe && !scl_oe);
   stall_c: cover property (scl_oe [*8]);
   stop_c: cover property ($fell(sda_oe) && scl_in);
endmodule // smbus_control_status_logic_sva
bind smbus_control_status_logic smbus_control_status_logic_sva #(.HALF_BIT(HALF_BIT)) chk_i (
   .ref_clk(ref_clk),
   .rst_b(rst_b),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .scl_in(scl_in),
   .scl_out(scl_out),
   .scl_oe(scl_oe),
   .sda_in(sda_in),
   .sda_out(sda_out),
   .sda_oe(sda_oe)
);

// ---- bus_peer_model.sv ----
// Behavioural bus target that acknowledges bytes or jams the data line.
`timescale 1ns/1ps
module bus_peer_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic ack_en,
   input wire logic jam,
   output logic sda_pull,
   output logic [7:0] rx_byte
);
   logic active = 1'b0;
   logic ack_q = 1'b0;
   logic scl_d = 1'b1;
   logic sda_d = 1'b1;
   logic [7:0] shift_q = 8'h00;
   int cnt = 0;
   // One process owns all peer state, so each variable has a single writer.
   always @(scl or sda) begin
      if (scl === 1'b1 && scl_d === 1'b1 && sda !== sda_d) begin
         // Data falling under a high clock starts a frame, rising ends it.
         active = (sda === 1'b0);
         cnt = 0;
      end else if (scl === 1'b1 && scl_d !== 1'b1) begin
         // Only clock edges move the peer, so a held clock stalls it as well.
         if (active) begin
            if (cnt < 8) begin
               shift_q = {shift_q[6:0], sda};
            end
            cnt = cnt + 1;
         end
      end else if (scl !== 1'b1 && scl_d === 1'b1) begin
         // The line is let go at the falling edge after the slot.
         ack_q = active && cnt == 8 && ack_en;
         if (cnt == 9) begin
            cnt = 0;
         end
      end
      scl_d = scl;
      sda_d = sda;
   end
   assign sda_pull = ack_q | (jam & active);
   assign rx_byte = shift_q;
endmodule // bus_peer_model

// ---- smbus_control_status_logic_tb.sv ----
// Self-checking bench of the bus control logic against a behavioural bus peer.
`timescale 1ns/1ps
module smbus_control_status_logic_tb;
   import smbus_ctl_pkg::*;
   localparam int unsigned HB = 8;
   logic ref_clk, rst_b, reg_wr, reg_rd, scl_out, scl_oe, sda_out, sda_oe;
   logic ack_en, jam, peer_pull;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_byte, d, dat;
   logic [31:0] rnd;
   int errors, samples_checked;
   wire scl_w = !scl_oe;
   wire sda_w = !(sda_oe | peer_pull);
   smbus_control_status_logic #(.HALF_BIT(HB)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
   bus_peer_model peer (.scl(scl_w), .sda(sda_w), .ack_en(ack_en), .jam(jam),
      .sda_pull(peer_pull), .rx_byte(rx_byte));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [7:0] after_byte(input logic a);
      return {2'b11, 4'h0, a, 1'b1};
   endfunction
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // Bounded wait on control bits; running out ends the run as a failure.
   task automatic poll(input logic [7:0] m, input logic [7:0] e, input string what);
      int n = 0;
      rd(CTL_ADDR, d);
      while ((d & m) !== e && n < 400) begin
         rd(CTL_ADDR, d);
         n++;
      end
      if (n >= 400) begin
         chk(what, d & m, e);
         conclude();
      end
   endtask
   task automatic xfer(input logic [7:0] v, input logic a);
      ack_en <= a;
      wr(DAT_ADDR, v);
      wr(BITW_BASE + 8'h05, 8'h01);
      poll(8'h01, 8'h01, "start si");
      chk("ctl start", d & 8'hfd, 8'he1);
      wr(BITW_BASE + 8'h05, 8'h00);
      wr(BITW_BASE, 8'h00);
      poll(8'h01, 8'h01, "byte si");
      chk("ctl byte", d, after_byte(a));
      chk("rx byte", rx_byte, v);
      wr(BITW_BASE + 8'h04, 8'h01);
      wr(BITW_BASE, 8'h00);
      poll(8'h91, 8'h00, "stop done");
      repeat (4 * HB) @(posedge ref_clk);
   endtask
   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      ack_en = 1'b1;
      jam = 1'b0;
      errors = 0;
      samples_checked = 0;
      rnd = 32'hf37aa42e;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd(CTL_ADDR, d);
      chk("ctl reset", d, CTL_RESET);
      rd(CFG_ADDR, d);
      chk("cfg reset", d, 8'h00);
      rd(8'h10, d);
      chk("unmapped", d, 8'h00);
      wr(CTL_ADDR, 8'hce);
      rd(CTL_ADDR, d);
      chk("read only bits", d, 8'h02);
      wr(BITW_BASE + 8'h01, 8'h00);
      rd(CTL_ADDR, d);
      chk("bit write", d, 8'h00);
      $display("register test done");
      wr(BITW_BASE, 8'h01);
      repeat (4) @(posedge ref_clk);
      chk("forced stall", {7'h00, scl_oe}, 8'h01);
      rd(CTL_ADDR, d);
      chk("forced si", d, 8'h01);
      wr(BITW_BASE, 8'h00);
      rd(CTL_ADDR, d);
      chk("si cleared", d, 8'h00);
      $display("interrupt test done");
      repeat (4 * HB) @(posedge ref_clk);
      for (int i = 0; i < 6; i++) begin
         rnd = xs(rnd);
         dat = (i == 2) ? 8'hfe : (i == 3) ? 8'h00 : {rnd[7:1], 1'b0};
         xfer(dat, (i < 2) ? (i == 0) : rnd[8]);
      end
      $display("transfer test done");
      ack_en <= 1'b1;
      wr(DAT_ADDR, 8'ha5);
      wr(BITW_BASE + 8'h05, 8'h01);
      poll(8'h01, 8'h01, "rd start");
      wr(BITW_BASE + 8'h05, 8'h00);
      wr(BITW_BASE, 8'h00);
      poll(8'h01, 8'h01, "rd addr");
      chk("rd addr ctl", d, 8'h83);
      wr(BITW_BASE, 8'h00);
      poll(8'h01, 8'h01, "rd byte");
      chk("rd byte ctl", d, 8'h8b);
      rd(DAT_ADDR, d);
      chk("rd data", d, 8'hff);
      wr(BITW_BASE + 8'h04, 8'h01);
      wr(BITW_BASE, 8'h00);
      poll(8'h91, 8'h00, "rd stop");
      chk("rd nack", d & 8'h0a, 8'h00);
      $display("receive test done");
      jam <= 1'b1;
      wr(DAT_ADDR, 8'hff);
      wr(BITW_BASE + 8'h05, 8'h01);
      poll(8'h01, 8'h01, "jam start");
      wr(BITW_BASE + 8'h05, 8'h00);
      wr(BITW_BASE, 8'h00);
      poll(8'h01, 8'h01, "jam si");
      chk("arb lost", d & 8'hc5, 8'h05);
      jam <= 1'b0;
      wr(BITW_BASE, 8'h00);
      rd(CTL_ADDR, d);
      chk("arb cleared", d & 8'h05, 8'h00);
      $display("arbitration test done");
      conclude();
   end
endmodule // smbus_control_status_logic_tb
